// ### common/scsl_pkg.sv
// scsl_pkg: constants and types shared by the system clock source selector
package scsl_pkg;
	// clock of this logic and its rate
	localparam int CLK_PERIOD_NS = 5;
	localparam longint CLK_HZ = 64'd1000000000 / CLK_PERIOD_NS;
	// three-bit source select field
	typedef logic [2:0] scsl_src_t;
	localparam scsl_src_t SRC_FAST_HI = 3'h0;
	localparam scsl_src_t SRC_EXT_PLL = 3'h2;
	localparam scsl_src_t SRC_SLOW = 3'h5;
	localparam scsl_src_t SRC_FAST_LO = 3'h6;
	localparam scsl_src_t SRC_EXT = 3'h7;
	// external mode select codes, 3 and 4 mean no external source
	localparam logic [2:0] EXT_CLOCK_HIGH_POWER = 3'h7;
	localparam logic [2:0] EXT_CLOCK_MEDIUM_POWER = 3'h6;
	localparam logic [2:0] EXT_CLOCK_LOW_POWER = 3'h5;
	localparam logic [2:0] HIGH_GAIN_RESONATOR_MODE = 3'h2;
	localparam logic [2:0] MEDIUM_GAIN_RESONATOR_MODE = 3'h1;
	localparam logic [2:0] LOW_POWER_CRYSTAL_MODE = 3'h0;
	// fast osc frequency codes 0..8 = 1,2,4,8,12,16,32,48,64 MHz
	localparam logic [3:0] FREQ_1MHZ = 4'h0;
	localparam logic [3:0] FREQ_64MHZ = 4'h8;
	// fixed slow osc rate
	localparam longint SLOW_OSC_HZ = 31000;
	// oscillator cycles counted before a resonator is stable
	localparam int STARTUP_OSC_CYCLES = 1024;
	// slow osc ticks without an external edge that mean failure
	localparam int FAIL_SLOW_TICKS = 3;
	// divider field: 2**n, n = 0..9
	localparam logic [3:0] DIV_MAX = 4'h9;
	localparam logic [3:0] DIV_RESET = 4'h0;
	// register bus
	localparam int AXI_ADDR_W = 8;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_FREQ = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam logic [7:0] REG_INT_STAT = 8'h0C;
	localparam logic [7:0] REG_INT_MASK = 8'h10;
	localparam int CTRL_DIV_LSB = 4;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// interrupt status bits
	localparam int INT_SWITCH = 0;
	localparam int INT_FAIL = 1;
	localparam int INT_READY = 2;
	localparam int INT_W = 3;
	localparam logic [INT_W-1:0] INT_RESET = 3'h0;

	// phase step giving a tick rate of hz out of CLK_HZ
	function automatic logic [31:0] nco_step(input longint hz);
		return 32'((hz << 32) / CLK_HZ);
	endfunction : nco_step

	// step for each fast osc frequency code
	function automatic logic [31:0] fast_step(input logic [3:0] code);
		longint mhz;
		case (code)
			4'h0: mhz = 1;
			4'h1: mhz = 2;
			4'h2: mhz = 4;
			4'h3: mhz = 8;
			4'h4: mhz = 12;
			4'h5: mhz = 16;
			4'h6: mhz = 32;
			4'h7: mhz = 48;
			default: mhz = 64;
		endcase
		return nco_step(mhz * 1000000);
	endfunction : fast_step

	localparam logic [31:0] SLOW_STEP = nco_step(SLOW_OSC_HZ);
endpackage : scsl_pkg

// ### rtl/scsl_pin_sync.sv
// scsl_pin_sync: three-stage pin synchroniser with agreement filter
module scsl_pin_sync (
	input wire logic clk,
	input wire logic reset,
	input wire logic pin,
	output logic level,
	output logic rise
);
	import scsl_pkg::*;

	logic s1_reg, s2_reg, s3_reg; // sync chain
	logic level_reg, level_next; // filtered level
	logic rise_reg, rise_next; // one-cycle rising edge

	// a change counts only when stages two and three agree
	always_comb
	begin
		level_next = (s2_reg == s3_reg) ? s3_reg : level_reg;
		rise_next = level_next && !level_reg;
	end

	// register the chain and the filtered result
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			s1_reg <= 1'b0;
			s2_reg <= 1'b0;
			s3_reg <= 1'b0;
			level_reg <= 1'b0;
			rise_reg <= 1'b0;
		end
		else
		begin
			s1_reg <= pin;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			level_reg <= level_next;
			rise_reg <= rise_next;
		end
	end

	assign level = level_reg;
	assign rise = rise_reg;
endmodule : scsl_pin_sync

// ### rtl/scsl_nco.sv
// scsl_nco: phase accumulator giving one-cycle ticks at a set rate
module scsl_nco #(
	parameter int W = 32
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [W-1:0] step,
	output logic tick
);
	import scsl_pkg::*;

	logic [W-1:0] acc_reg, acc_next; // phase
	logic tick_reg, tick_next; // carry out
	logic [W:0] sum; // phase plus step with carry

	// carry out of the phase marks one oscillator period
	always_comb
	begin
		sum = {1'b0, acc_reg} + {1'b0, step};
		acc_next = sum[W-1:0];
		tick_next = sum[W];
	end

	// register phase and tick
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			acc_reg <= '0;
			tick_reg <= 1'b0;
		end
		else
		begin
			acc_reg <= acc_next;
			tick_reg <= tick_next;
		end
	end

	assign tick = tick_reg;
endmodule : scsl_nco

// ### rtl/scsl_clock_select.sv
// scsl_clock_select: system clock source selector with AXI4-Lite registers
module scsl_clock_select (
	input wire logic clk,
	input wire logic reset,
	input wire logic [scsl_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [scsl_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic primary_osc_input,
	input wire scsl_pkg::scsl_src_t reset_source_select,
	input wire logic [2:0] external_mode_select,
	input wire logic clock_out_enable_n,
	input wire logic fail_monitor_enable,
	input wire logic wake_from_sleep,
	output logic sys_clk_tick,
	output logic secondary_osc_out,
	output logic secondary_osc_oe_n,
	output logic irq
);
	import scsl_pkg::*;

	typedef enum logic [1:0] {SW_IDLE, SW_WAIT_READY, SW_WAIT_EDGE} scsl_sw_t;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	logic ext_rise; // synchronised external clock edge
	logic fast_tick, slow_tick; // internal oscillator ticks
	logic mode_res, mode_ec; // external mode decode
	// startup counter state
	logic [10:0] st_cnt_reg, st_cnt_next;
	logic ext_ok_reg, ext_ok_next;
	// period measure and multiplier
	logic [15:0] per_cnt_reg, per_cnt_next;
	logic [13:0] quarter_reg, quarter_next;
	logic [13:0] pll_cnt_reg, pll_cnt_next;
	logic [1:0] edges_reg, edges_next;
	logic [2:0] pll_seen_reg, pll_seen_next; // ticks since edge, checking only
	logic per_valid, pll_tick;
	// failure monitor
	logic [2:0] miss_cnt_reg, miss_cnt_next;
	logic ext_dead, ext_in_use, fail_now;
	// source mux, divider, output
	logic sel_tick, req_ready, div_tick, src_change;
	logic [8:0] div_cnt_reg, div_cnt_next, div_mask;
	logic sys_tick_reg;
	logic [1:0] co_cnt_reg, co_cnt_next;
	logic co_out_reg, co_out_next, co_oe_n_reg, co_oe_n_next, drive_now;
	// switch control and registers
	scsl_sw_t sw_reg, sw_next;
	scsl_src_t cur_src_reg, cur_src_next, req_src_reg, req_src_next;
	logic [3:0] cur_div_reg, cur_div_next, req_div_reg, req_div_next;
	logic [3:0] freq_reg, freq_next;
	logic [INT_W-1:0] int_reg, int_next, mask_reg, mask_next, int_set;
	logic commit;
	// bus slave
	logic aw_full_reg, aw_full_next, w_full_reg, w_full_next;
	logic [AXI_ADDR_W-1:0] aw_addr_reg, aw_addr_next;
	logic [31:0] w_data_reg, w_data_next, rd_val;
	logic w_lane_reg, w_lane_next; // byte lane 0 enabled
	logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next, rd_ok;
	logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
	logic [31:0] rdata_reg, rdata_next;
	logic wr_fire, wr_en, ctrl_wr, freq_wr;

	// primary input is a pin, so it goes through the filter
	scsl_pin_sync u_ext_sync (
		.clk(clk),
		.reset(reset),
		.pin(primary_osc_input),
		.level(),
		.rise(ext_rise)
	);

	// fast internal osc, rate from the frequency register
	scsl_nco #(.W(32)) u_fast (
		.clk(clk),
		.reset(reset),
		.step(fast_step(freq_reg)),
		.tick(fast_tick)
	);

	// slow internal osc, step is a constant no write reaches
	scsl_nco #(.W(32)) u_slow (
		.clk(clk),
		.reset(reset),
		.step(SLOW_STEP),
		.tick(slow_tick)
	);

	// external mode decode
	always_comb
	begin
		mode_ec = external_mode_select inside {EXT_CLOCK_LOW_POWER,
			EXT_CLOCK_MEDIUM_POWER, EXT_CLOCK_HIGH_POWER};
		mode_res = external_mode_select inside {LOW_POWER_CRYSTAL_MODE,
			MEDIUM_GAIN_RESONATOR_MODE, HIGH_GAIN_RESONATOR_MODE};
	end

	// startup counter: resonators count edges, logic clocks go at once
	always_comb
	begin
		st_cnt_next = st_cnt_reg;
		ext_ok_next = ext_ok_reg;
		if (wake_from_sleep)
		begin
			st_cnt_next = 11'h000;
			ext_ok_next = mode_ec;
		end
		else if (mode_ec)
			ext_ok_next = 1'b1;
		else if (!mode_res)
			ext_ok_next = 1'b0;
		else if (!ext_ok_reg && ext_rise)
		begin
			st_cnt_next = st_cnt_reg + 11'h001;
			if (st_cnt_reg == 11'(STARTUP_OSC_CYCLES - 1))
				ext_ok_next = 1'b1;
		end
	end

	// period measure: multiplier ticks every quarter of the input period
	always_comb
	begin
		per_cnt_next = (per_cnt_reg == 16'hFFFF) ? per_cnt_reg : per_cnt_reg + 16'h0001;
		quarter_next = quarter_reg;
		edges_next = edges_reg;
		pll_cnt_next = pll_cnt_reg + 14'h0001;
		pll_seen_next = (pll_seen_reg == 3'h7) ? pll_seen_reg : pll_seen_reg + 3'(pll_tick);
		if (pll_tick)
			pll_cnt_next = 14'h0000;
		if (ext_rise)
		begin
			per_cnt_next = 16'h0001;
			quarter_next = per_cnt_reg[15:2];
			edges_next = (edges_reg == 2'h2) ? edges_reg : edges_reg + 2'h1;
			pll_cnt_next = 14'h0000;
			pll_seen_next = 3'h0;
		end
	end

	// two edges give a first period, only then the multiplier runs
	assign per_valid = (edges_reg == 2'h2);
	assign pll_tick = per_valid && (quarter_reg != 14'h0000) && (pll_cnt_reg == quarter_reg - 14'h0001);

	// failure monitor: slow ticks counted between external edges
	always_comb
	begin
		miss_cnt_next = miss_cnt_reg;
		if (ext_rise)
			miss_cnt_next = 3'h0;
		else if (slow_tick && !ext_dead)
			miss_cnt_next = miss_cnt_reg + 3'h1;
	end

	assign ext_dead = (miss_cnt_reg == 3'(FAIL_SLOW_TICKS));
	assign ext_in_use = (cur_src_reg == SRC_EXT) || (cur_src_reg == SRC_EXT_PLL);
	assign fail_now = fail_monitor_enable && ext_in_use && ext_dead;

	// source mux; an external source gives no ticks until it is stable
	always_comb
	begin
		sel_tick = fast_tick;
		req_ready = 1'b1;
		case (cur_src_reg)
			SRC_EXT: sel_tick = ext_rise && ext_ok_reg;
			SRC_EXT_PLL: sel_tick = pll_tick && ext_ok_reg;
			SRC_SLOW: sel_tick = slow_tick;
			default: sel_tick = fast_tick;
		endcase
		case (req_src_reg)
			SRC_EXT: req_ready = ext_ok_reg && !ext_dead;
			SRC_EXT_PLL: req_ready = ext_ok_reg && per_valid && !ext_dead;
			default: req_ready = 1'b1;
		endcase
	end

	// post divider 2**n; a stopped source stops everything after it
	always_comb
	begin
		div_mask = 9'((10'h001 << cur_div_reg) - 10'h001);
		div_tick = sel_tick && ((div_cnt_reg & div_mask) == div_mask);
		div_cnt_next = src_change ? 9'h000 : div_cnt_reg + 9'(sel_tick);
	end

	// clock out: Fosc/4, only when the pin is not used by a resonator
	always_comb
	begin
		drive_now = !clock_out_enable_n && !(ext_in_use && mode_res);
		co_cnt_next = co_cnt_reg + 2'(div_tick);
		co_out_next = drive_now && co_cnt_reg[1];
		co_oe_n_next = !drive_now;
	end

	// switch sequence: wait for the new source, then for a finished cycle
	always_comb
	begin
		sw_next = sw_reg;
		cur_src_next = cur_src_reg;
		cur_div_next = cur_div_reg;
		req_src_next = req_src_reg;
		req_div_next = req_div_reg;
		commit = 1'b0;
		unique case (sw_reg)
			SW_IDLE: sw_next = SW_IDLE;
			SW_WAIT_READY:
			begin
				if (req_ready)
					sw_next = SW_WAIT_EDGE;
			end
			SW_WAIT_EDGE:
			begin
				// a dead source never ends its cycle, so it may be left at once
				if (div_tick || (ext_in_use && ext_dead))
				begin
					commit = 1'b1;
					cur_src_next = req_src_reg;
					cur_div_next = req_div_reg;
					sw_next = SW_IDLE;
				end
			end
		endcase
		// a new request replaces one still waiting
		if (ctrl_wr)
		begin
			req_src_next = w_data_reg[2:0];
			req_div_next = (w_data_reg[CTRL_DIV_LSB +: 4] > DIV_MAX) ? DIV_MAX
				: w_data_reg[CTRL_DIV_LSB +: 4];
			sw_next = SW_WAIT_READY;
		end
		// failure overrides any switch in progress
		if (fail_now)
		begin
			cur_src_next = SRC_FAST_LO;
			commit = 1'b0;
			sw_next = SW_IDLE;
		end
	end

	assign src_change = commit || fail_now;

	// frequency, mask and sticky interrupt bits; a set beats a clear
	always_comb
	begin
		freq_next = freq_reg;
		mask_next = mask_reg;
		int_set = '0;
		int_set[INT_SWITCH] = commit;
		int_set[INT_FAIL] = fail_now;
		int_set[INT_READY] = ext_ok_next && !ext_ok_reg;
		int_next = int_reg;
		if (freq_wr)
			freq_next = (w_data_reg[3:0] > FREQ_64MHZ) ? FREQ_64MHZ : w_data_reg[3:0];
		if (wr_en && aw_addr_reg == REG_INT_MASK)
			mask_next = w_data_reg[INT_W-1:0];
		if (wr_en && aw_addr_reg == REG_INT_STAT)
			int_next = int_reg & ~w_data_reg[INT_W-1:0];
		int_next = int_next | int_set;
	end

	// write pairs address and data in either order; reads answer next cycle
	assign s_axi_awready = !aw_full_reg && !bvalid_reg;
	assign s_axi_wready = !w_full_reg && !bvalid_reg;
	assign s_axi_arready = !rvalid_reg;
	assign wr_fire = aw_full_reg && w_full_reg && !bvalid_reg;
	assign wr_en = wr_fire && w_lane_reg;
	assign ctrl_wr = wr_en && (aw_addr_reg == REG_CTRL);
	assign freq_wr = wr_en && (aw_addr_reg == REG_FREQ);

	// read decode
	always_comb
	begin
		rd_ok = 1'b1;
		case (s_axi_araddr)
			REG_CTRL: rd_val = {24'h000000, req_div_reg, 1'b0, req_src_reg};
			REG_FREQ: rd_val = {28'h0000000, freq_reg};
			REG_STATUS: rd_val = {20'h00000, sw_reg != SW_IDLE, ext_dead, per_valid,
				ext_ok_reg, cur_div_reg, 1'b0, cur_src_reg};
			REG_INT_STAT: rd_val = 32'(int_reg);
			REG_INT_MASK: rd_val = 32'(mask_reg);
			default:
			begin
				rd_val = 32'h00000000;
				rd_ok = 1'b0;
			end
		endcase
	end

	// bus channel state
	always_comb
	begin
		aw_full_next = aw_full_reg;
		aw_addr_next = aw_addr_reg;
		w_full_next = w_full_reg;
		w_data_next = w_data_reg;
		w_lane_next = w_lane_reg;
		bvalid_next = bvalid_reg;
		bresp_next = bresp_reg;
		rvalid_next = rvalid_reg;
		rdata_next = rdata_reg;
		rresp_next = rresp_reg;
		if (s_axi_awvalid && s_axi_awready)
		begin
			aw_full_next = 1'b1;
			aw_addr_next = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			w_full_next = 1'b1;
			w_data_next = s_axi_wdata;
			w_lane_next = s_axi_wstrb[0];
		end
		if (wr_fire)
		begin
			aw_full_next = 1'b0;
			w_full_next = 1'b0;
			bvalid_next = 1'b1;
			bresp_next = (aw_addr_reg inside {REG_CTRL, REG_FREQ, REG_STATUS,
				REG_INT_STAT, REG_INT_MASK}) ? RESP_OKAY : RESP_SLVERR;
		end
		else if (bvalid_reg && s_axi_bready)
			bvalid_next = 1'b0;
		if (s_axi_arvalid && s_axi_arready)
		begin
			rvalid_next = 1'b1;
			rdata_next = rd_val;
			rresp_next = rd_ok ? RESP_OKAY : RESP_SLVERR;
		end
		else if (rvalid_reg && s_axi_rready)
			rvalid_next = 1'b0;
	end

	// clock, startup and monitor state; reset loads the configured source
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			st_cnt_reg <= 11'h000;
			ext_ok_reg <= 1'b0;
			per_cnt_reg <= 16'h0000;
			quarter_reg <= 14'h0000;
			pll_cnt_reg <= 14'h0000;
			pll_seen_reg <= 3'h0;
			edges_reg <= 2'h0;
			miss_cnt_reg <= 3'h0;
			div_cnt_reg <= 9'h000;
			sys_tick_reg <= 1'b0;
			co_cnt_reg <= 2'h0;
			co_out_reg <= 1'b0;
			co_oe_n_reg <= 1'b1;
			sw_reg <= SW_IDLE;
			cur_src_reg <= reset_source_select;
			req_src_reg <= reset_source_select;
			cur_div_reg <= DIV_RESET;
			req_div_reg <= DIV_RESET;
			freq_reg <= (reset_source_select == SRC_FAST_LO) ? FREQ_1MHZ : FREQ_64MHZ;
			mask_reg <= INT_RESET;
			int_reg <= INT_RESET;
		end
		else
		begin
			st_cnt_reg <= st_cnt_next;
			ext_ok_reg <= ext_ok_next;
			per_cnt_reg <= per_cnt_next;
			quarter_reg <= quarter_next;
			pll_cnt_reg <= pll_cnt_next;
			pll_seen_reg <= pll_seen_next;
			edges_reg <= edges_next;
			miss_cnt_reg <= miss_cnt_next;
			div_cnt_reg <= div_cnt_next;
			sys_tick_reg <= div_tick;
			co_cnt_reg <= co_cnt_next;
			co_out_reg <= co_out_next;
			co_oe_n_reg <= co_oe_n_next;
			sw_reg <= sw_next;
			cur_src_reg <= cur_src_next;
			req_src_reg <= req_src_next;
			cur_div_reg <= cur_div_next;
			req_div_reg <= req_div_next;
			freq_reg <= freq_next;
			mask_reg <= mask_next;
			int_reg <= int_next;
		end
	end

	// bus registers
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			aw_full_reg <= 1'b0;
			aw_addr_reg <= '0;
			w_full_reg <= 1'b0;
			w_data_reg <= 32'h00000000;
			w_lane_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg <= RESP_OKAY;
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h00000000;
			rresp_reg <= RESP_OKAY;
		end
		else
		begin
			aw_full_reg <= aw_full_next;
			aw_addr_reg <= aw_addr_next;
			w_full_reg <= w_full_next;
			w_data_reg <= w_data_next;
			w_lane_reg <= w_lane_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			rvalid_reg <= rvalid_next;
			rdata_reg <= rdata_next;
			rresp_reg <= rresp_next;
		end
	end

	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;
	assign sys_clk_tick = sys_tick_reg;
	assign secondary_osc_out = co_out_reg;
	assign secondary_osc_oe_n = co_oe_n_reg;
	assign irq = |(int_reg & mask_reg);

	// switch steps
	sequence edge_wait_s;
		sw_reg == SW_WAIT_EDGE && div_tick && !fail_now;
	endsequence
	sequence src_moved_s;
		$changed(cur_src_reg) && !$past(fail_now);
	endsequence

	reset_source_a: assert property (disable iff (1'b0) reset ##1 !reset |->
		cur_src_reg == $past(reset_source_select)) else $error("reset source not loaded");
	ec_bypass_a: assert property (mode_ec && !wake_from_sleep |=> ext_ok_reg)
		else $error("logic clock mode still waiting");
	startup_count_a: assert property ($rose(ext_ok_reg) && mode_res |->
		$past(st_cnt_reg) == 11'(STARTUP_OSC_CYCLES - 1)) else $error("resonator ready early");
	fail_switch_a: assert property (fail_now |=> cur_src_reg == SRC_FAST_LO && int_reg[INT_FAIL])
		else $error("no fallback on clock loss");
	freq_range_a: assert property (freq_wr |=> freq_reg <= FREQ_64MHZ)
		else $error("fast osc code out of range");
	clkout_pin_a: assert property (!secondary_osc_oe_n |->
		$past(!clock_out_enable_n && !(ext_in_use && mode_res))) else $error("clock out on busy pin");
	static_halt_a: assert property (!sel_tick && !src_change |=> !sys_clk_tick && $stable(div_cnt_reg))
		else $error("tick without source edge");
	switch_commit_a: assert property (edge_wait_s |=> cur_src_reg == $past(req_src_reg))
		else $error("switch not taken at cycle end");
	switch_ready_a: assert property (src_moved_s |-> $past(sw_reg) == SW_WAIT_EDGE
		&& ($past(div_tick) || $past(ext_dead))) else $error("source changed mid cycle");
	pll_rate_a: assert property (cur_src_reg == SRC_EXT_PLL && ext_rise && $stable(quarter_reg)
		&& per_valid |-> pll_seen_reg inside {[3'h3:3'h5]}) else $error("multiplier not four");
endmodule : scsl_clock_select

// ### sim/scsl_osc_model.sv
// scsl_osc_model: external clock source seen at the primary oscillator input
module scsl_osc_model (
	input wire logic clk,
	input wire logic run,
	input wire logic [7:0] half,
	output logic pin
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] cnt_reg = 8'h00; // cycles spent in the current half period
	initial pin = 1'b0;
	// square wave on the clk grid; a stopped source rests low, never floats
	always @(posedge clk)
	begin
		if (!run)
		begin
			pin <= 1'b0;
			cnt_reg <= 8'h00;
		end
		else if (cnt_reg >= half - 8'h01)
		begin
			pin <= ~pin;
			cnt_reg <= 8'h00;
		end
		else
			cnt_reg <= cnt_reg + 8'h01;
	end
endmodule : scsl_osc_model

// ### sim/tb.sv
// tb: self-checking bench for the system clock source selector
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import scsl_pkg::*;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	logic [31:0] s_axi_rdata, rd;
	logic primary_osc_input, sys_clk_tick, secondary_osc_out, secondary_osc_oe_n, irq;
	scsl_src_t reset_source_select = SRC_FAST_LO;
	logic [2:0] external_mode_select = EXT_CLOCK_MEDIUM_POWER;
	logic clock_out_enable_n = 1'b0, fail_monitor_enable = 1'b0, wake_from_sleep = 1'b0;
	logic osc_run = 1'b1; // partner source running
	logic [7:0] osc_half = 8'h04; // partner half period in clk cycles
	int n_mismatch = 0, total_checks = 0, cyc = 0, nt, ng, g;

	scsl_clock_select u_dut (.clk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .primary_osc_input,
		.reset_source_select, .external_mode_select, .clock_out_enable_n, .fail_monitor_enable, .wake_from_sleep,
		.sys_clk_tick, .secondary_osc_out, .secondary_osc_oe_n, .irq);
	scsl_osc_model u_osc (.clk, .run(osc_run), .half(osc_half), .pin(primary_osc_input));

	initial forever #2.5 clk = ~clk;
	// hang guard: the fallback wait is the longest stretch
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 100000)
		begin
			n_mismatch++;
			summarize();
		end
	end

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[ERR] %s expected %0h seen %0h", what, exp, got);
		end
	endtask : check

	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : summarize

	task automatic do_reset(input scsl_src_t s, input logic [2:0] m);
		@(posedge clk);
		reset <= 1'b1;
		reset_source_select <= s;
		external_mode_select <= m;
		repeat (16) @(posedge clk);
		reset <= 1'b0;
	endtask : do_reset

	// readies depend on registers only, so the falling edge shows what the next rising edge takes
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic pa, pw, ta, tw, hit;
		pa = 1'b1;
		pw = 1'b1;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (pa || pw)
		begin
			@(negedge clk);
			ta = pa && s_axi_awready;
			tw = pw && s_axi_wready;
			@(posedge clk);
			if (ta)
				s_axi_awvalid <= 1'b0;
			if (tw)
				s_axi_wvalid <= 1'b0;
			pa = pa && !ta;
			pw = pw && !tw;
		end
		do
		begin
			@(negedge clk);
			hit = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge clk);
		end while (!hit);
		s_axi_bready <= 1'b0;
	endtask : wr

	task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic hit;
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(negedge clk);
			hit = s_axi_arready;
			@(posedge clk);
		end while (!hit);
		s_axi_arvalid <= 1'b0;
		do
		begin
			@(negedge clk);
			hit = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge clk);
		end while (!hit);
		s_axi_rready <= 1'b0;
	endtask : rdr

	// poll until no switch is pending; rd keeps the last status
	task automatic wait_idle();
		do rdr(REG_STATUS, rd, rs);
		while (rd[11] !== 1'b0);
	endtask : wait_idle

	// ticks and clock-out toggles over n cycles
	task automatic count(input int n);
		logic prev;
		nt = 0;
		ng = 0;
		prev = secondary_osc_out;
		repeat (n)
		begin
			@(negedge clk);
			nt += (sys_clk_tick === 1'b1);
			ng += (secondary_osc_out !== prev);
			prev = secondary_osc_out;
		end
	endtask : count

	task automatic t_reset();
		rdr(REG_STATUS, rd, rs);
		check("reset source", 32'(SRC_FAST_LO), 32'(rd[2:0]));
		check("ext ready", 32'h1, 32'(rd[8]));
		rdr(REG_FREQ, rd, rs);
		check("reset freq", 32'(FREQ_1MHZ), rd);
		check("clock out oe", 32'h0, 32'(secondary_osc_oe_n));
		for (int i = 0; i < 10; i++)
		begin
			wr(REG_FREQ, (i == 9) ? 32'hF : 32'(i), rs);
			rdr(REG_FREQ, rd, rs);
			check("freq code", (i == 9) ? 32'(FREQ_64MHZ) : 32'(i), rd);
		end
		wr(8'h14, 32'h1, rs);
		check("unmapped write", 32'(RESP_SLVERR), 32'(rs));
		rdr(8'h14, rd, rs);
		check("unmapped read", 32'(RESP_SLVERR), 32'(rs));
		$display("test reset and registers done");
	endtask : t_reset

	task automatic t_slow();
		wr(REG_INT_MASK, 32'h1 << INT_SWITCH, rs);
		wr(REG_CTRL, 32'(SRC_SLOW), rs);
		wait_idle();
		check("slow source", 32'(SRC_SLOW), 32'(rd[2:0]));
		check("switch irq", 32'h1, 32'(irq));
		wr(REG_INT_MASK, 32'h0, rs);
		check("masked irq", 32'h0, 32'(irq));
		wr(REG_INT_STAT, 32'h1 << INT_SWITCH, rs);
		rdr(REG_INT_STAT, rd, rs);
		check("switch flag clear", 32'h0, 32'(rd[INT_SWITCH]));
		g = 0;
		do @(negedge clk);
		while (sys_clk_tick !== 1'b1);
		do
		begin
			@(negedge clk);
			g++;
		end while (sys_clk_tick !== 1'b1);
		check("slow period", 32'h1, 32'(g >= 6450 && g <= 6454));
		$display("test slow switch done");
	endtask : t_slow

	task automatic t_ext();
		wr(REG_CTRL, 32'(SRC_EXT) | (32'h1 << CTRL_DIV_LSB), rs);
		wait_idle();
		check("ext source", 32'(SRC_EXT), 32'(rd[2:0]));
		check("ext divider", 32'h1, 32'(rd[7:4]));
		count(320);
		check("ext ticks", 32'h1, 32'(nt >= 19 && nt <= 21));
		check("clock out toggles", 32'h1, 32'(ng >= 9 && ng <= 11));
		@(posedge clk);
		osc_run <= 1'b0;
		repeat (8) @(posedge clk);
		count(200);
		check("halted ticks", 32'h0, 32'(nt));
		@(posedge clk);
		osc_run <= 1'b1;
		count(320);
		check("resumed ticks", 32'h1, 32'(nt >= 18 && nt <= 21));
		wr(REG_CTRL, 32'(SRC_EXT_PLL), rs);
		wait_idle();
		check("pll source", 32'(SRC_EXT_PLL), 32'(rd[2:0]));
		count(320);
		check("pll ticks", 32'h1, 32'(nt >= 156 && nt <= 164));
		$display("test external switch done");
	endtask : t_ext

	task automatic t_res_fail();
		osc_half <= 8'h03;
		do_reset(SRC_EXT, LOW_POWER_CRYSTAL_MODE);
		count(3000);
		check("early ticks", 32'h0, 32'(nt));
		check("resonator pin free", 32'h1, 32'(secondary_osc_oe_n));
		rdr(REG_STATUS, rd, rs);
		check("early stable", 32'h0, 32'(rd[8]));
		repeat (5000) @(posedge clk);
		rdr(REG_STATUS, rd, rs);
		check("late stable", 32'h1, 32'(rd[8]));
		check("reset ext source", 32'(SRC_EXT), 32'(rd[2:0]));
		@(posedge clk);
		wake_from_sleep <= 1'b1;
		@(posedge clk);
		wake_from_sleep <= 1'b0;
		rdr(REG_STATUS, rd, rs);
		check("wake restarts count", 32'h0, 32'(rd[8]));
		fail_monitor_enable <= 1'b1;
		wr(REG_INT_MASK, 32'h1 << INT_FAIL, rs);
		@(posedge clk);
		osc_run <= 1'b0;
		do @(negedge clk);
		while (irq !== 1'b1);
		rdr(REG_STATUS, rd, rs);
		check("fallback source", 32'(SRC_FAST_LO), 32'(rd[2:0]));
		rdr(REG_INT_STAT, rd, rs);
		check("fail flag", 32'h1, 32'(rd[INT_FAIL]));
		external_mode_select <= EXT_CLOCK_HIGH_POWER;
		rdr(REG_STATUS, rd, rs);
		check("logic mode ready", 32'h1, 32'(rd[8]));
		$display("test resonator and fallback done");
	endtask : t_res_fail

	initial
	begin
		do_reset(SRC_FAST_LO, EXT_CLOCK_MEDIUM_POWER);
		t_reset();
		t_slow();
		t_ext();
		t_res_fail();
		summarize();
	end
endmodule : tb
